/* rtl/pcic_pkg.sv */
// shared constants and types for the pin-change interrupt configuration block
package pcic_pkg;

    // register addresses
    localparam logic [7:0] PCIC_ADDR_ENABLE = 8'h02;
    localparam logic [7:0] PCIC_ADDR_DEFAULT = 8'h03;
    localparam logic [7:0] PCIC_ADDR_SOURCE = 8'h04;
    localparam logic [7:0] PCIC_ADDR_CONFIG = 8'h05;
    localparam logic [7:0] PCIC_ADDR_FLAG = 8'h07;
    localparam logic [7:0] PCIC_ADDR_CAPTURE = 8'h08;
    localparam logic [7:0] PCIC_ADDR_PORT = 8'h09;
    localparam logic [7:0] PCIC_ADDR_LAST = 8'h0a;
    localparam logic [7:0] PCIC_ADDR_FIRST = 8'h00;
    localparam logic [7:0] PCIC_ADDR_STEP = 8'h01;

    // configuration register bit positions
    localparam int PCIC_BIT_AUTOINC_DIS = 5;
    localparam int PCIC_BIT_OPEN_DRAIN = 2;
    localparam int PCIC_BIT_POLARITY = 1;
    localparam int PCIC_BIT_CLEAR_SRC = 0;

    // reset values
    localparam logic [7:0] PCIC_RST_BYTE = 8'h00;
    localparam logic [7:0] PCIC_RST_POINTER = 8'h00;

    // pin synchroniser depth; reference load waits for it to fill
    localparam int PCIC_SYNC_STAGES = 2;
    localparam logic [1:0] PCIC_ARM_CYCLES = 2'h2;

    // implemented configuration fields
    typedef struct packed {
        logic pointer_autoinc_disable;
        logic irq_open_drain_select;
        logic irq_polarity_select;
        logic irq_clear_source_select;
    } pcic_cfg_t;

    localparam pcic_cfg_t PCIC_RST_CFG = '{1'b0, 1'b0, 1'b0, 1'b0};

    // arm: reference being loaded, idle: watching, pend: interrupt held
    typedef enum logic [2:0] {
        PCIC_ST_ARM = 3'b001,
        PCIC_ST_IDLE = 3'b010,
        PCIC_ST_PEND = 3'b100
    } pcic_state_t;

endpackage

/* rtl/pcic_core.sv */
// interrupt-on-change configuration, decision, capture and register port
`timescale 1ns/1ps

//
// Overview of operation
// - enable bit turns pin monitoring on
// - default mode: opposite level raises interrupt
// - source bit picks default or previous
// - bit five stops pointer auto-increment
// - bit two selects open-drain, ignores polarity
// - bit one sets active-drive polarity
// - bit zero picks capture or port read
// - clear only when mismatch is gone
// - bits seven, six, four, three read zero
// - only enabled input pins cause interrupts
// - first event captures port, no re-capture
// - clear after read's last bit, not write
module pcic_core
#(
    parameter int PINS = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // port pins and direction (1 = input)
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] dir_is_input,
    // byte port from the serial engine
    input wire logic ptr_load,
    input wire logic [7:0] ptr_value,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic rd_strobe,
    input wire logic rd_done,
    output logic [7:0] reg_rdata,
    output logic [7:0] reg_pointer,
    // interrupt pin
    output logic irq_o,
    output logic irq_oe
);
    import pcic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [PINS-1:0] sync_a;
    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] change_interrupt_enable;
    logic [PINS-1:0] default_compare_value;
    logic [PINS-1:0] compare_source_select;
    logic [PINS-1:0] prev_ref;
    logic [PINS-1:0] capture_register;
    logic [PINS-1:0] flag_bits;
    logic [1:0] arm_cnt;
    pcic_cfg_t cfg;
    pcic_state_t state;
    pcic_state_t next_state;
    logic [PINS-1:0] mismatch;
    logic [7:0] cfg_byte;
    logic [7:0] next_rdata;
    logic [7:0] next_pointer;
    logic [7:0] clear_addr;
    logic any_mismatch;
    logic clear_ok;
    logic next_irq_o;
    logic next_irq_oe;
    logic byte_end;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync_a <= '0;
            pin_sync <= '0;
        end
        else
        begin
            sync_a <= pin_in;
            pin_sync <= sync_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin mismatch decision

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            // enable and direction gate, compare source
            assign mismatch[gi] = change_interrupt_enable[gi] && dir_is_input[gi] && (state != PCIC_ST_ARM) &&
                (compare_source_select[gi] ? (pin_sync[gi] != default_compare_value[gi])
                                           : (pin_sync[gi] != prev_ref[gi]));
        end
    endgenerate

    assign any_mismatch = |mismatch;

    assign clear_addr = cfg.irq_clear_source_select ? PCIC_ADDR_CAPTURE : PCIC_ADDR_PORT;
    // clear after read completes, mismatch gone
    assign clear_ok = rd_done && (reg_pointer == clear_addr) && !any_mismatch;

    always_comb
    begin
        next_state = state;
        case (state)
            PCIC_ST_ARM:
                if (arm_cnt == PCIC_ARM_CYCLES)
                    next_state = PCIC_ST_IDLE;
            PCIC_ST_IDLE:
                if (any_mismatch)
                    next_state = PCIC_ST_PEND;
            PCIC_ST_PEND:
                if (clear_ok)
                    next_state = PCIC_ST_IDLE;
            default:
                next_state = PCIC_ST_ARM;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt state, capture and reference

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state <= PCIC_ST_ARM;
            arm_cnt <= '0;
            prev_ref <= '0;
            capture_register <= '0;
            flag_bits <= '0;
        end
        else
        begin
            state <= next_state;
            if (state == PCIC_ST_ARM)
                arm_cnt <= arm_cnt + 2'h1;
            // reference loads at arm end and on clear
            if ((state == PCIC_ST_ARM && next_state == PCIC_ST_IDLE) || (state == PCIC_ST_PEND && clear_ok))
                prev_ref <= pin_sync;
            // capture only on the first event
            if (state == PCIC_ST_IDLE && any_mismatch)
            begin
                capture_register <= pin_sync;
                flag_bits <= mismatch;
            end
            else if (state == PCIC_ST_PEND && clear_ok)
                flag_bits <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port

    assign cfg_byte = {2'h0, cfg.pointer_autoinc_disable, 2'h0, cfg.irq_open_drain_select,
                       cfg.irq_polarity_select, cfg.irq_clear_source_select};

    assign next_rdata = (reg_pointer == PCIC_ADDR_ENABLE) ? 8'(change_interrupt_enable) :
                        (reg_pointer == PCIC_ADDR_DEFAULT) ? 8'(default_compare_value) :
                        (reg_pointer == PCIC_ADDR_SOURCE) ? 8'(compare_source_select) :
                        (reg_pointer == PCIC_ADDR_CONFIG) ? cfg_byte :
                        (reg_pointer == PCIC_ADDR_FLAG) ? 8'(flag_bits) :
                        (reg_pointer == PCIC_ADDR_CAPTURE) ? 8'(capture_register) :
                        (reg_pointer == PCIC_ADDR_PORT) ? 8'(pin_sync) : PCIC_RST_BYTE;

    // a finished byte, read or written, moves the pointer
    assign byte_end = wr_strobe || rd_done;
    // pointer hold or increment, wrapping after the last register
    assign next_pointer = ptr_load ? ptr_value :
                          (!byte_end || cfg.pointer_autoinc_disable) ? reg_pointer :
                          (reg_pointer == PCIC_ADDR_LAST) ? PCIC_ADDR_FIRST : reg_pointer + PCIC_ADDR_STEP;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            change_interrupt_enable <= '0;
            default_compare_value <= '0;
            compare_source_select <= '0;
            cfg <= PCIC_RST_CFG;
            reg_rdata <= PCIC_RST_BYTE;
            reg_pointer <= PCIC_RST_POINTER;
        end
        else
        begin
            reg_pointer <= next_pointer;
            if (rd_strobe)
                reg_rdata <= next_rdata;
            if (wr_strobe)
            begin
                if (reg_pointer == PCIC_ADDR_ENABLE)
                    change_interrupt_enable <= wr_data[PINS-1:0];
                if (reg_pointer == PCIC_ADDR_DEFAULT)
                    default_compare_value <= wr_data[PINS-1:0];
                if (reg_pointer == PCIC_ADDR_SOURCE)
                    compare_source_select <= wr_data[PINS-1:0];
                if (reg_pointer == PCIC_ADDR_CONFIG)
                    cfg <= '{wr_data[PCIC_BIT_AUTOINC_DIS], wr_data[PCIC_BIT_OPEN_DRAIN],
                             wr_data[PCIC_BIT_POLARITY], wr_data[PCIC_BIT_CLEAR_SRC]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt pin drive

    // open-drain pulls low only while pending, polarity
    assign next_irq_oe = cfg.irq_open_drain_select ? (state == PCIC_ST_PEND) : 1'b1;
    assign next_irq_o = cfg.irq_open_drain_select ? 1'b0 :
                        ((state == PCIC_ST_PEND) ? cfg.irq_polarity_select : !cfg.irq_polarity_select);

    // pin lags the state by one cycle so it comes straight from a flop
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            irq_o <= 1'b1;
            irq_oe <= 1'b1;
        end
        else
        begin
            irq_o <= next_irq_o;
            irq_oe <= next_irq_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_clear_read;
        state == PCIC_ST_PEND && rd_done && reg_pointer == clear_addr && !any_mismatch;
    endsequence

    sequence s_back_idle;
        ##1 state == PCIC_ST_IDLE && flag_bits == '0;
    endsequence

    a_input_gate_only: assert property ((mismatch & ~(change_interrupt_enable & dir_is_input)) == '0)
        else $error("mismatch on a disabled or output pin");
    a_enable_needed: assert property ($rose(state == PCIC_ST_PEND) |->
        $past(|(change_interrupt_enable & dir_is_input)))
        else $error("interrupt raised with no enabled input");
    a_default_compare: assert property ((state == PCIC_ST_IDLE &&
        |(change_interrupt_enable & dir_is_input & compare_source_select & (pin_sync ^ default_compare_value)))
        |=> state == PCIC_ST_PEND)
        else $error("default mismatch did not raise interrupt");
    a_previous_compare: assert property ((state == PCIC_ST_IDLE &&
        |(change_interrupt_enable & dir_is_input & ~compare_source_select & (pin_sync ^ prev_ref)))
        |=> state == PCIC_ST_PEND)
        else $error("pin change did not raise interrupt");
    a_pointer_hold: assert property (byte_end && !ptr_load && cfg.pointer_autoinc_disable |=> $stable(reg_pointer))
        else $error("pointer moved with auto-increment off");
    a_pointer_step: assert property (byte_end && !ptr_load && !cfg.pointer_autoinc_disable &&
        reg_pointer != PCIC_ADDR_LAST |=> reg_pointer == $past(reg_pointer) + PCIC_ADDR_STEP)
        else $error("pointer did not increment");
    a_open_drain_pin: assert property ($past(cfg.irq_open_drain_select) |->
        irq_o == 1'b0 && irq_oe == $past(state == PCIC_ST_PEND))
        else $error("open-drain pin drive wrong");
    a_active_level: assert property (!$past(cfg.irq_open_drain_select) |-> irq_oe &&
        irq_o == ($past(state == PCIC_ST_PEND) ? $past(cfg.irq_polarity_select) : !$past(cfg.irq_polarity_select)))
        else $error("active-drive pin level wrong");
    a_clear_on_read: assert property (s_clear_read |-> s_back_idle)
        else $error("selected read did not clear interrupt");
    a_clear_blocked: assert property (state == PCIC_ST_PEND && any_mismatch |=> state == PCIC_ST_PEND)
        else $error("interrupt cleared while mismatch present");
    a_write_no_clear: assert property (state == PCIC_ST_PEND && !rd_done |=> state == PCIC_ST_PEND)
        else $error("interrupt cleared without a completed read");
    a_capture_frozen: assert property (state == PCIC_ST_PEND |=> $stable(capture_register))
        else $error("capture changed while pending");
    a_config_zeros: assert property (rd_strobe && reg_pointer == PCIC_ADDR_CONFIG |=>
        reg_rdata[7:6] == 2'h0 && reg_rdata[4:3] == 2'h0)
        else $error("unimplemented configuration bits not zero");
    a_ref_reload: assert property (s_clear_read |=> prev_ref == $past(pin_sync))
        else $error("reference not reloaded on clear");

    // capture and flags load together, once, on the entry to pending
    a_capture_entry: assert property (state == PCIC_ST_IDLE && any_mismatch |=>
        capture_register == $past(pin_sync))
        else $error("capture not loaded on interrupt entry");
    a_flag_entry: assert property (state == PCIC_ST_IDLE && any_mismatch |=>
        flag_bits == $past(mismatch))
        else $error("flags not loaded on interrupt entry");
    // the port read must show the synchronised pins, never the raw ones
    a_port_read: assert property (rd_strobe && reg_pointer == PCIC_ADDR_PORT |=>
        reg_rdata == 8'($past(pin_sync)))
        else $error("port read not taken from synchronised pins");
    a_autoinc_write: assert property (wr_strobe && reg_pointer == PCIC_ADDR_CONFIG |=>
        cfg.pointer_autoinc_disable == $past(wr_data[PCIC_BIT_AUTOINC_DIS]))
        else $error("auto-increment control not written");

endmodule

/* dv/pcic_host.sv */
// host-side model that reaches the block's registers through its byte port
`timescale 1ns/1ps
module pcic_host
(
    // clock
    input wire logic clk,
    // byte port toward the block
    output logic ptr_load,
    output logic [7:0] ptr_value,
    output logic wr_strobe,
    output logic [7:0] wr_data,
    output logic rd_strobe,
    output logic rd_done,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        {ptr_load, wr_strobe, rd_strobe, rd_done} = 4'h0;
        ptr_value = 8'h00;
        wr_data = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    task put_ptr(input logic [7:0] a);
        @(posedge clk);
        ptr_load <= 1'b1;
        ptr_value <= a;
        @(posedge clk);
        ptr_load <= 1'b0;
        // released address lines must not keep a stale value
        ptr_value <= ~a;
    endtask
    task write_reg(input logic [7:0] a, input logic [7:0] d);
        put_ptr(a);
        wr_strobe <= 1'b1;
        wr_data <= d;
        @(posedge clk);
        wr_strobe <= 1'b0;
        wr_data <= ~d;
    endtask
    task read_reg(input logic [7:0] a, output logic [7:0] d);
        put_ptr(a);
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        rd_done <= 1'b1;
        @(posedge clk);
        rd_done <= 1'b0;
        d = reg_rdata;
    endtask
    // default, source first
    // enable goes off first so a half-written setup cannot raise a stray interrupt
    task setup_change(input logic [7:0] en, input logic [7:0] dv, input logic [7:0] src);
        write_reg(8'h02, 8'h00);
        write_reg(8'h03, dv);
        write_reg(8'h04, src);
        write_reg(8'h02, en);
    endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the pin-change interrupt block
`timescale 1ns/1ps
module tb_top;
    import pcic_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] pin_in = 8'h00;
    logic [7:0] dir_is_input = 8'hff;
    logic ptr_load, wr_strobe, rd_strobe, rd_done, irq_o, irq_oe;
    logic [7:0] ptr_value, wr_data, reg_rdata, reg_pointer, d;
    int err_total = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    pcic_core #(.PINS(8)) u_pcic_core (.clk(clk), .sys_rst(sys_rst), .pin_in(pin_in),
        .dir_is_input(dir_is_input), .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_done(rd_done), .reg_rdata(reg_rdata),
        .reg_pointer(reg_pointer), .irq_o(irq_o), .irq_oe(irq_oe));
    pcic_host u_pcic_host (.clk(clk), .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_done(rd_done), .reg_rdata(reg_rdata));
    ////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // expected pin pair {irq_o, irq_oe} for pending state and drive settings
    function automatic logic [1:0] irq_exp(input logic pend, input logic od, input logic pol);
        return pend ? (od ? 2'b01 : {pol, 1'b1}) : (od ? 2'b00 : {~pol, 1'b1});
    endfunction
    task chk_irq(input logic pend, input logic od, input logic pol);
        chk({6'h00, irq_o, irq_oe}, {6'h00, irq_exp(pend, od, pol)}, "irq pins");
    endtask
    task wait_irq(input logic od, input logic pol);
        int i;
        for (i = 0; i < 20 && {irq_o, irq_oe} !== irq_exp(1'b1, od, pol); i++)
            @(posedge clk);
        if (i == 20)
        begin
            chk_irq(1'b1, od, pol);
            end_of_test();
        end
    endtask
    task set_pin(input logic [7:0] v);
        @(posedge clk);
        pin_in <= v;
        repeat (8) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk_irq(1'b0, 1'b0, 1'b0);
        for (int a = 2; a < 6; a++)
        begin
            u_pcic_host.read_reg(a[7:0], d);
            chk(d, 8'h00, "reset value");
        end
        u_pcic_host.write_reg(8'h06, 8'hff);
        u_pcic_host.read_reg(8'h06, d);
        chk(d, 8'h00, "unmapped");
        u_pcic_host.write_reg(8'h02, 8'h5a);
        // pointer is updated by the write edge itself, so look once it has settled
        @(negedge clk);
        chk(reg_pointer, 8'h03, "pointer step");
        u_pcic_host.read_reg(8'h02, d);
        chk(d, 8'h5a, "enable reg");
        u_pcic_host.write_reg(8'h05, 8'hff);
        u_pcic_host.read_reg(8'h05, d);
        chk(d, 8'h27, "config bits");
        u_pcic_host.write_reg(8'h05, 8'h26);
        @(negedge clk);
        chk(reg_pointer, 8'h05, "pointer hold");
        chk_irq(1'b0, 1'b1, 1'b1);
        // default compare, open drain, clear on port read
        u_pcic_host.write_reg(8'h05, 8'h06);
        u_pcic_host.setup_change(8'hff, 8'h00, 8'hff);
        set_pin(8'h01);
        wait_irq(1'b1, 1'b1);
        set_pin(8'h03);
        u_pcic_host.read_reg(8'h08, d);
        chk(d, 8'h01, "capture first");
        u_pcic_host.read_reg(8'h07, d);
        chk(d, 8'h01, "flags first");
        u_pcic_host.read_reg(8'h09, d);
        chk(d, 8'h03, "port read");
        set_pin(8'h03);
        chk_irq(1'b1, 1'b1, 1'b1);
        set_pin(8'h00);
        u_pcic_host.write_reg(8'h09, 8'h00);
        u_pcic_host.read_reg(8'h08, d);
        set_pin(8'h00);
        chk_irq(1'b1, 1'b1, 1'b1);
        u_pcic_host.read_reg(8'h09, d);
        set_pin(8'h00);
        chk_irq(1'b0, 1'b1, 1'b1);
        // push-pull active high, clear on capture read
        u_pcic_host.write_reg(8'h05, 8'h03);
        set_pin(8'h80);
        wait_irq(1'b0, 1'b1);
        set_pin(8'h00);
        u_pcic_host.read_reg(8'h09, d);
        set_pin(8'h00);
        chk_irq(1'b1, 1'b0, 1'b1);
        u_pcic_host.read_reg(8'h08, d);
        set_pin(8'h00);
        chk_irq(1'b0, 1'b0, 1'b1);
        // previous-value compare, active low
        u_pcic_host.write_reg(8'h05, 8'h00);
        u_pcic_host.setup_change(8'hff, 8'hff, 8'h00);
        set_pin(8'h00);
        chk_irq(1'b0, 1'b0, 1'b0);
        set_pin(8'h10);
        wait_irq(1'b0, 1'b0);
        set_pin(8'h00);
        u_pcic_host.read_reg(8'h09, d);
        set_pin(8'h00);
        chk_irq(1'b0, 1'b0, 1'b0);
        // output pins and disabled pins stay quiet
        dir_is_input <= 8'hfe;
        set_pin(8'h01);
        chk_irq(1'b0, 1'b0, 1'b0);
        set_pin(8'h00);
        dir_is_input <= 8'hff;
        u_pcic_host.write_reg(8'h02, 8'hfd);
        set_pin(8'h02);
        chk_irq(1'b0, 1'b0, 1'b0);
        end_of_test();
    end
endmodule
